//--- common/pmr_pkg.sv
package pmr_pkg;

   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_MAIN_CONTROL = 6'h00;
   localparam logic [5:0] IDX_LOW_POWER_CONFIG = 6'h01;
   localparam logic [5:0] IDX_RESET_PIN_CONTROL = 6'h02;
   localparam logic [5:0] IDX_CORE_PRESCALE = 6'h08;
   localparam logic [5:0] IDX_BUS_A_PRESCALE = 6'h09;
   localparam logic [5:0] IDX_BUS_B_PRESCALE = 6'h0A;
   localparam logic [5:0] IDX_BUS_C_PRESCALE = 6'h0B;
   localparam logic [5:0] IDX_HS_GATE = 6'h14;
   localparam logic [5:0] IDX_BUS_A_GATE = 6'h18;
   localparam logic [5:0] IDX_BUS_B_GATE = 6'h1C;
   localparam logic [5:0] IDX_BUS_C_GATE = 6'h20;
   localparam logic [5:0] IDX_IRQ_ENABLE_CLEAR = 6'h34;
   localparam logic [5:0] IDX_IRQ_ENABLE_SET = 6'h35;
   localparam logic [5:0] IDX_IRQ_FLAGS = 6'h36;
   localparam logic [5:0] IDX_LAST_RESET_SOURCE = 6'h38;

   // field positions
   localparam int FDET_ON_BIT = 2;
   localparam int BACKUP_SEL_BIT = 4;
   localparam int PIN_DISABLE_BIT = 0;
   localparam int READY_FLAG_BIT = 0;
   localparam int FAIL_FLAG_BIT = 1;
   localparam int IDLE_W = 2;
   localparam int DIV_W = 3;
   localparam int IRQ_W = 2;
   localparam int CAUSE_W = 7;

   // reset source bit layout: power-on, two brown-outs, pin, watchdog, system request
   localparam logic [6:0] CAUSE_MASK = 7'h77;

   // defined bits and reset values of the clock gates
   localparam logic [31:0] HS_GATE_MASK = 32'h0000007F;
   localparam logic [31:0] BUS_A_GATE_MASK = 32'h0000007F;
   localparam logic [31:0] BUS_B_GATE_MASK = 32'h0000003F;
   localparam logic [31:0] BUS_C_GATE_MASK = 32'h000007FF;
   localparam logic [31:0] HS_GATE_RESET = 32'h0000007F;
   localparam logic [31:0] BUS_A_GATE_RESET = 32'h0000007F;
   localparam logic [31:0] BUS_B_GATE_RESET = 32'h0000003F;
   localparam logic [31:0] BUS_C_GATE_RESET = 32'h000007FF;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic RUN_RESET = 1'b1;

   // ahb-lite sizes and transfer type bit
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam int HTRANS_ACTIVE_BIT = 1;

   typedef enum logic [1:0] {
      IDLE_CORE = 2'b00,
      IDLE_HSBUS = 2'b01,
      IDLE_PBUS = 2'b10,
      IDLE_RSVD = 2'b11
   } pmr_idle_e;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_RD_FETCH = 2'b10,
      BUS_RD_DONE = 2'b11
   } pmr_bus_e;

endpackage

//--- verilog/pmr_sync2.sv
`timescale 1ns/10ps
// two-stage synchroniser for pin levels
module pmr_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pmr_sync_s;

   pmr_sync_s st;
   pmr_sync_s next_st;

   // first stage feeds only the second
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule // pmr_sync2

//--- verilog/pmr_prescaler.sv
`timescale 1ns/10ps
// power-of-two divider giving one tick every 2**sel cycles
module pmr_prescaler (
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   typedef struct packed {
      logic [6:0] cnt;
      logic tick;
   } pmr_presc_s;

   pmr_presc_s st;
   pmr_presc_s next_st;
   logic [6:0] limit;

   // limit is 2**sel - 1, so sel 0 ticks every cycle
   always_comb begin
      limit = 7'h7F >> (3'h7 - sel);
      next_st = st;
      if (!run) begin
         next_st.cnt = 7'h00;
         next_st.tick = 1'b0;
      end else if (st.cnt >= limit) begin
         next_st.cnt = 7'h00; // a lowered ratio restarts cleanly
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 7'h01;
         next_st.tick = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule // pmr_prescaler

//--- verilog/pmr_power_manager.sv
`timescale 1ns/10ps
module pmr_power_manager (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic write_protect,
   input wire logic standby,
   input wire logic sleep_idle,
   input wire logic clock_ready_event,
   input wire logic clock_failure_event,
   input wire logic [6:0] reset_cause,
   input wire logic ondemand_req_pin,
   input wire logic async_irq_pin,
   output logic irq,
   output logic backup_main_select,
   output logic failure_detector_on,
   output logic reset_pin_disable,
   output logic [31:0] highspeed_bus_clock_gate,
   output logic [31:0] bus_a_clock_gate,
   output logic [31:0] bus_b_clock_gate,
   output logic [31:0] bus_c_clock_gate,
   output logic core_divider_tick,
   output logic bus_a_divider_tick,
   output logic bus_b_divider_tick,
   output logic bus_c_divider_tick,
   output logic core_clock_run,
   output logic highspeed_bus_run,
   output logic peripheral_bus_run,
   output logic sleepwalk_clock_on,
   output logic wake_request
);
   typedef struct packed {
      pmr_pkg::pmr_bus_e bus;
      logic [5:0] dp_idx;
      logic [3:0] dp_lanes;
      logic [31:0] rdata;
      logic backup_sel;
      logic fdet_on;
      logic [1:0] idle_level;
      logic pin_dis;
      logic [2:0] core_div;
      logic [2:0] a_div;
      logic [2:0] b_div;
      logic [2:0] c_div;
      logic [31:0] hs_gate;
      logic [31:0] a_gate;
      logic [31:0] b_gate;
      logic [31:0] c_gate;
      logic [1:0] irq_en;
      logic [1:0] irq_flag;
      logic [6:0] rst_src;
      logic src_taken;
      logic irq;
      logic core_run;
      logic hs_run;
      logic pb_run;
      logic walk_clk;
      logic wake;
   } pmr_state_s;

   localparam pmr_state_s ST_RESET = '{
      bus: pmr_pkg::BUS_IDLE, dp_idx: 6'h00, dp_lanes: 4'h0, rdata: 32'h00000000,
      backup_sel: 1'b0, fdet_on: 1'b0, idle_level: 2'h0, pin_dis: 1'b0,
      core_div: 3'h0, a_div: 3'h0, b_div: 3'h0, c_div: 3'h0,
      hs_gate: pmr_pkg::HS_GATE_RESET, a_gate: pmr_pkg::BUS_A_GATE_RESET,
      b_gate: pmr_pkg::BUS_B_GATE_RESET, c_gate: pmr_pkg::BUS_C_GATE_RESET,
      irq_en: 2'h0, irq_flag: 2'h0, rst_src: 7'h00, src_taken: 1'b0, irq: 1'b0,
      core_run: pmr_pkg::RUN_RESET, hs_run: pmr_pkg::RUN_RESET, pb_run: pmr_pkg::RUN_RESET,
      walk_clk: 1'b0, wake: 1'b0
   };

   pmr_state_s st;
   pmr_state_s next_st;
   logic [1:0] pin_sync;
   logic accept;
   logic writing;
   logic fail_evt;
   logic ready_evt;
   logic [3:0] lanes;
   logic [31:0] lane_mask;
   logic [31:0] rd_word;
   logic [31:0] merged;
   logic [31:0] wbits;

   // pin levels from peripherals on other clocks
   pmr_sync2 #(.W(2)) u_pin_sync (
      .clk(clk),
      .nrst(nrst),
      .d({async_irq_pin, ondemand_req_pin}),
      .q(pin_sync)
   );

   // divider ticks follow the domain run flags
   pmr_prescaler u_core_div (.clk(clk), .nrst(nrst), .run(st.core_run), .sel(st.core_div),
      .tick(core_divider_tick));
   pmr_prescaler u_a_div (.clk(clk), .nrst(nrst), .run(st.pb_run), .sel(st.a_div),
      .tick(bus_a_divider_tick));
   pmr_prescaler u_b_div (.clk(clk), .nrst(nrst), .run(st.pb_run), .sel(st.b_div),
      .tick(bus_b_divider_tick));
   pmr_prescaler u_c_div (.clk(clk), .nrst(nrst), .run(st.pb_run), .sel(st.c_div),
      .tick(bus_c_divider_tick));

   // byte lanes of a new address phase
   always_comb begin
      if (hsize == pmr_pkg::HSIZE_BYTE) begin
         lanes = 4'(4'h1 << haddr[1:0]);
      end else if (hsize == pmr_pkg::HSIZE_HALF) begin
         lanes = haddr[1] ? 4'hC : 4'h3;
      end else begin
         lanes = 4'hF;
      end
   end

   assign lane_mask = {{8{st.dp_lanes[3]}}, {8{st.dp_lanes[2]}}, {8{st.dp_lanes[1]}}, {8{st.dp_lanes[0]}}};
   assign accept = hsel && hready && htrans[pmr_pkg::HTRANS_ACTIVE_BIT];
   // frozen in standby, and protection blocks every register write
   assign writing = (st.bus == pmr_pkg::BUS_WRITE) && !write_protect && !standby;
   // the detector does not monitor during standby
   assign fail_evt = clock_failure_event && st.fdet_on && !standby;
   assign ready_evt = clock_ready_event && !standby;
   assign merged = (rd_word & ~lane_mask) | (hwdata & lane_mask);
   assign wbits = hwdata & lane_mask;

   // register read view; undefined bits and unmapped words read zero
   always_comb begin
      rd_word = 32'h00000000;
      unique case (st.dp_idx)
         pmr_pkg::IDX_MAIN_CONTROL: begin
            rd_word[pmr_pkg::BACKUP_SEL_BIT] = st.backup_sel;
            rd_word[pmr_pkg::FDET_ON_BIT] = st.fdet_on;
         end
         pmr_pkg::IDX_LOW_POWER_CONFIG: rd_word[pmr_pkg::IDLE_W-1:0] = st.idle_level;
         pmr_pkg::IDX_RESET_PIN_CONTROL: rd_word[pmr_pkg::PIN_DISABLE_BIT] = st.pin_dis;
         pmr_pkg::IDX_CORE_PRESCALE: rd_word[pmr_pkg::DIV_W-1:0] = st.core_div;
         pmr_pkg::IDX_BUS_A_PRESCALE: rd_word[pmr_pkg::DIV_W-1:0] = st.a_div;
         pmr_pkg::IDX_BUS_B_PRESCALE: rd_word[pmr_pkg::DIV_W-1:0] = st.b_div;
         pmr_pkg::IDX_BUS_C_PRESCALE: rd_word[pmr_pkg::DIV_W-1:0] = st.c_div;
         pmr_pkg::IDX_HS_GATE: rd_word = st.hs_gate;
         pmr_pkg::IDX_BUS_A_GATE: rd_word = st.a_gate;
         pmr_pkg::IDX_BUS_B_GATE: rd_word = st.b_gate;
         pmr_pkg::IDX_BUS_C_GATE: rd_word = st.c_gate;
         pmr_pkg::IDX_IRQ_ENABLE_CLEAR: rd_word[pmr_pkg::IRQ_W-1:0] = st.irq_en;
         pmr_pkg::IDX_IRQ_ENABLE_SET: rd_word[pmr_pkg::IRQ_W-1:0] = st.irq_en;
         pmr_pkg::IDX_IRQ_FLAGS: rd_word[pmr_pkg::IRQ_W-1:0] = st.irq_flag;
         pmr_pkg::IDX_LAST_RESET_SOURCE: rd_word[pmr_pkg::CAUSE_W-1:0] = st.rst_src;
         default: rd_word = 32'h00000000;
      endcase
   end

   // next state of the whole block
   always_comb begin
      next_st = st;
      // bus phases: reads take one wait state so a preceding write is visible
      unique case (st.bus)
         pmr_pkg::BUS_RD_FETCH: begin
            next_st.bus = pmr_pkg::BUS_RD_DONE;
            next_st.rdata = rd_word;
         end
         pmr_pkg::BUS_IDLE, pmr_pkg::BUS_WRITE, pmr_pkg::BUS_RD_DONE: begin
            if (accept) begin
               next_st.bus = hwrite ? pmr_pkg::BUS_WRITE : pmr_pkg::BUS_RD_FETCH;
               next_st.dp_idx = haddr[7:2];
               next_st.dp_lanes = lanes;
            end else begin
               next_st.bus = pmr_pkg::BUS_IDLE;
            end
         end
      endcase
      // register writes, reserved bits are never stored
      if (writing) begin
         unique case (st.dp_idx)
            pmr_pkg::IDX_MAIN_CONTROL: begin
               next_st.backup_sel = merged[pmr_pkg::BACKUP_SEL_BIT];
               next_st.fdet_on = merged[pmr_pkg::FDET_ON_BIT];
            end
            pmr_pkg::IDX_LOW_POWER_CONFIG: next_st.idle_level = merged[pmr_pkg::IDLE_W-1:0];
            pmr_pkg::IDX_RESET_PIN_CONTROL: next_st.pin_dis = merged[pmr_pkg::PIN_DISABLE_BIT];
            pmr_pkg::IDX_CORE_PRESCALE: next_st.core_div = merged[pmr_pkg::DIV_W-1:0];
            pmr_pkg::IDX_BUS_A_PRESCALE: next_st.a_div = merged[pmr_pkg::DIV_W-1:0];
            pmr_pkg::IDX_BUS_B_PRESCALE: next_st.b_div = merged[pmr_pkg::DIV_W-1:0];
            pmr_pkg::IDX_BUS_C_PRESCALE: next_st.c_div = merged[pmr_pkg::DIV_W-1:0];
            pmr_pkg::IDX_HS_GATE: next_st.hs_gate = merged & pmr_pkg::HS_GATE_MASK;
            pmr_pkg::IDX_BUS_A_GATE: next_st.a_gate = merged & pmr_pkg::BUS_A_GATE_MASK;
            pmr_pkg::IDX_BUS_B_GATE: next_st.b_gate = merged & pmr_pkg::BUS_B_GATE_MASK;
            pmr_pkg::IDX_BUS_C_GATE: next_st.c_gate = merged & pmr_pkg::BUS_C_GATE_MASK;
            pmr_pkg::IDX_IRQ_ENABLE_CLEAR: next_st.irq_en = st.irq_en & ~wbits[pmr_pkg::IRQ_W-1:0];
            pmr_pkg::IDX_IRQ_ENABLE_SET: next_st.irq_en = st.irq_en | wbits[pmr_pkg::IRQ_W-1:0];
            pmr_pkg::IDX_IRQ_FLAGS: next_st.irq_flag = st.irq_flag & ~wbits[pmr_pkg::IRQ_W-1:0];
            default: next_st.irq_flag = st.irq_flag; // unmapped or read-only: write dropped
         endcase
      end
      // hardware events come after the writes so a set wins over a clear
      if (fail_evt) begin
         next_st.backup_sel = 1'b1;
         next_st.irq_flag[pmr_pkg::FAIL_FLAG_BIT] = 1'b1;
      end
      if (ready_evt) begin
         next_st.irq_flag[pmr_pkg::READY_FLAG_BIT] = 1'b1;
      end
      // reset cause caught once, on the first edge after release
      if (!st.src_taken) begin
         next_st.rst_src = reset_cause & pmr_pkg::CAUSE_MASK;
         next_st.src_taken = 1'b1;
      end
      next_st.irq = |(next_st.irq_flag & next_st.irq_en);
      // domain run flags: deeper idle levels stop more domains, reserved acts as deepest
      next_st.core_run = !(sleep_idle || standby);
      next_st.hs_run = !standby && !(sleep_idle && st.idle_level != pmr_pkg::IDLE_CORE);
      next_st.pb_run = !standby && !(sleep_idle && (st.idle_level == pmr_pkg::IDLE_PBUS
         || st.idle_level == pmr_pkg::IDLE_RSVD));
      // sleepwalking clocks and wake-up only matter while in standby
      next_st.walk_clk = standby && pin_sync[0];
      next_st.wake = standby && pin_sync[1];
   end

   // the block keeps its main clock in every idle level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign hrdata = st.rdata;
   assign hreadyout = (st.bus != pmr_pkg::BUS_RD_FETCH);
   assign hresp = 1'b0;
   assign irq = st.irq;
   assign backup_main_select = st.backup_sel;
   assign failure_detector_on = st.fdet_on;
   assign reset_pin_disable = st.pin_dis;
   assign highspeed_bus_clock_gate = st.hs_gate;
   assign bus_a_clock_gate = st.a_gate;
   assign bus_b_clock_gate = st.b_gate;
   assign bus_c_clock_gate = st.c_gate;
   assign core_clock_run = st.core_run;
   assign highspeed_bus_run = st.hs_run;
   assign peripheral_bus_run = st.pb_run;
   assign sleepwalk_clock_on = st.walk_clk;
   assign wake_request = st.wake;

   // checks on the guarded behaviour
   AST_FAIL_FLAG: assert property (@(posedge clk) disable iff (!nrst)
      fail_evt |=> st.irq_flag[pmr_pkg::FAIL_FLAG_BIT] && backup_main_select)
      else $error("failure flag or backup select missed");
   AST_READY_FLAG: assert property (@(posedge clk) disable iff (!nrst)
      ready_evt && !st.irq_en[pmr_pkg::READY_FLAG_BIT] |=> st.irq_flag[pmr_pkg::READY_FLAG_BIT])
      else $error("ready flag not set while disabled");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
      irq == |(st.irq_flag & st.irq_en))
      else $error("irq does not match enabled flags");
   AST_EN_SET: assert property (@(posedge clk) disable iff (!nrst)
      writing && st.dp_idx == pmr_pkg::IDX_IRQ_ENABLE_SET && wbits[1:0] == 2'h0 |=> $stable(st.irq_en))
      else $error("enable changed by a zero write");
   AST_EN_CLR: assert property (@(posedge clk) disable iff (!nrst)
      writing && st.dp_idx == pmr_pkg::IDX_IRQ_ENABLE_CLEAR && wbits[0]
      |=> !st.irq_en[0] && (irq == (st.irq_flag[1] && st.irq_en[1])))
      else $error("enable clear failed");
   AST_FLAG_CLR: assert property (@(posedge clk) disable iff (!nrst)
      writing && st.dp_idx == pmr_pkg::IDX_IRQ_FLAGS && wbits[1] && !fail_evt
      |=> !st.irq_flag[pmr_pkg::FAIL_FLAG_BIT])
      else $error("flag not cleared by one");
   AST_PROTECT: assert property (@(posedge clk) disable iff (!nrst)
      st.bus == pmr_pkg::BUS_WRITE && write_protect |=> $stable(st.hs_gate) && $stable(st.core_div))
      else $error("protected register written");
   AST_FREEZE: assert property (@(posedge clk) disable iff (!nrst)
      standby |=> $stable(st.irq_flag) && $stable(st.irq_en) && $stable(backup_main_select))
      else $error("state moved in standby");
   AST_READ_WAIT: assert property (@(posedge clk) disable iff (!nrst)
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst)
      st.bus == pmr_pkg::BUS_RD_DONE && st.dp_idx == pmr_pkg::IDX_MAIN_CONTROL |-> (hrdata & 32'hFFFFFFEB) == 32'h0)
      else $error("reserved bits read non-zero");
   AST_IDLE_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
      sleep_idle && !standby && st.idle_level == pmr_pkg::IDLE_CORE && $stable(st.idle_level)
      |=> !core_clock_run && highspeed_bus_run && peripheral_bus_run)
      else $error("idle level 0 stopped wrong domains");
   AST_WAKE: assert property (@(posedge clk) disable iff (!nrst)
      standby && pin_sync[1] |=> wake_request)
      else $error("no wake on async interrupt");
   // standby, sleepwalk and clock stop checks; a stray tick in standby would burn power
   AST_RUN_STANDBY: assert property (@(posedge clk) disable iff (!nrst)
      standby |=> !core_clock_run && !highspeed_bus_run && !peripheral_bus_run)
      else $error("domain still running in standby");
   AST_WALK: assert property (@(posedge clk) disable iff (!nrst)
      standby && pin_sync[0] |=> sleepwalk_clock_on)
      else $error("on-demand clock not started");
   AST_NO_WALK: assert property (@(posedge clk) disable iff (!nrst)
      !standby |=> !sleepwalk_clock_on && !wake_request)
      else $error("sleepwalk output outside standby");
   AST_WRITE_NOWAIT: assert property (@(posedge clk) disable iff (!nrst)
      accept && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   AST_TICK_STOP: assert property (@(posedge clk) disable iff (!nrst)
      !st.core_run |=> !core_divider_tick)
      else $error("core tick while domain stopped");
   AST_FDET_OFF: assert property (@(posedge clk) disable iff (!nrst)
      clock_failure_event && !st.fdet_on && !writing
      |=> $stable(st.irq_flag[pmr_pkg::FAIL_FLAG_BIT]))
      else $error("failure seen with detector off");
   AST_GATE_RSVD: assert property (@(posedge clk) disable iff (!nrst)
      (highspeed_bus_clock_gate & ~pmr_pkg::HS_GATE_MASK) == 32'h0 && (bus_a_clock_gate & ~pmr_pkg::BUS_A_GATE_MASK) == 32'h0
      && (bus_b_clock_gate & ~pmr_pkg::BUS_B_GATE_MASK) == 32'h0 && (bus_c_clock_gate & ~pmr_pkg::BUS_C_GATE_MASK) == 32'h0)
      else $error("reserved gate bit set");
   AST_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
      !st.src_taken |=> st.rst_src == ($past(reset_cause) & pmr_pkg::CAUSE_MASK))
      else $error("reset source not captured");
   AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
      ready_evt |=> st.irq_flag[pmr_pkg::READY_FLAG_BIT])
      else $error("ready flag lost to a clear");
endmodule // pmr_power_manager

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
   logic clk, nrst, hsel, hwrite, write_protect, standby, sleep_idle, clock_ready_event, clock_failure_event;
   logic ondemand_req_pin, async_irq_pin, rd_ph, hreadyout, hresp, irq, bsel, fdon, rpd;
   logic core_run, hs_run, pb_run, walk_on, wake, t_core, t_a, t_b, t_c;
   logic [31:0] haddr, hwdata, hrdata, g_hs, g_a, g_b, g_c, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] reset_cause;
   logic [31:0] exp_q[$];
   int fails, n_compared, seed, k, n, ticks;

   pmr_power_manager DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .write_protect(write_protect), .standby(standby), .sleep_idle(sleep_idle),
      .clock_ready_event(clock_ready_event), .clock_failure_event(clock_failure_event), .reset_cause(reset_cause),
      .ondemand_req_pin(ondemand_req_pin), .async_irq_pin(async_irq_pin), .irq(irq), .backup_main_select(bsel),
      .failure_detector_on(fdon), .reset_pin_disable(rpd), .highspeed_bus_clock_gate(g_hs), .bus_a_clock_gate(g_a),
      .bus_b_clock_gate(g_b), .bus_c_clock_gate(g_c), .core_divider_tick(t_core), .bus_a_divider_tick(t_a),
      .bus_b_divider_tick(t_b), .bus_c_divider_tick(t_c), .core_clock_run(core_run), .highspeed_bus_run(hs_run),
      .peripheral_bus_run(pb_run), .sleepwalk_clock_on(walk_on), .wake_request(wake));

   // free-running 100 mhz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ready looked at mid-cycle so the decision never races the edge
   task automatic wait_rdy;
      for (k = 0; k < 20; k++) begin
         @(negedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (k == 20) begin
         fails++;
         $display("Error hready expected 1 seen stuck low");
         conclude();
      end
      @(posedge clk);
   endtask

   // one ahb-lite single transfer; for reads d is the expected word
   task automatic bus(input logic w, input logic [5:0] idx, input logic [1:0] ln, input logic [2:0] sz,
         input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; hsize <= sz; haddr <= {24'h000000, idx, ln};
      wait_rdy();
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_ph <= ~w;
      if (!w) exp_q.push_back(d);
      wait_rdy();
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b1, idx, 2'b00, 3'h2, d);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b0, idx, 2'b00, 3'h2, d);
   endtask

   // read data taken from the queue when the completing cycle shows it
   always @(negedge clk) begin
      if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
         check("hresp", hresp, 32'h0);
         if (exp_q.size() > 0) check("hrdata", hrdata, exp_q.pop_front());
         else check("read_note", 32'h0, 32'h1);
      end
   end

   // hang guard, far beyond the whole sequence
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("Error run expected end seen timeout");
      conclude();
   end

   initial begin
      {hsel, hwrite, write_protect, standby, sleep_idle, clock_ready_event, clock_failure_event} = 7'h00;
      {ondemand_req_pin, async_irq_pin, rd_ph, htrans, hsize} = 8'h00;
      haddr = 32'h00000000; hwdata = 32'h00000000; reset_cause = 7'h7F; seed = 76; nrst = 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("irq", irq, 32'h0);
      check("hs_gate", g_hs, pmr_pkg::HS_GATE_RESET);
      check("fdet", fdon, 32'h0);
      check("a_gate", g_a, pmr_pkg::BUS_A_GATE_RESET);
      rd(pmr_pkg::IDX_MAIN_CONTROL, 32'h00);
      rd(pmr_pkg::IDX_LAST_RESET_SOURCE, {25'h0, 7'h7F & pmr_pkg::CAUSE_MASK});
      rd(6'h3F, 32'h0);
      wr(pmr_pkg::IDX_IRQ_ENABLE_SET, 32'h1);
      wr(pmr_pkg::IDX_IRQ_ENABLE_SET, 32'h0);
      rd(pmr_pkg::IDX_IRQ_ENABLE_CLEAR, 32'h1);
      clock_ready_event <= 1'b1;
      @(posedge clk);
      clock_ready_event <= 1'b0;
      repeat (2) @(posedge clk);
      check("irq", irq, 32'h1);
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h1);
      wr(pmr_pkg::IDX_IRQ_FLAGS, 32'h0);
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h1);
      wr(pmr_pkg::IDX_IRQ_FLAGS, 32'h1);
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h0);
      check("irq", irq, 32'h0);
      wr(pmr_pkg::IDX_IRQ_ENABLE_SET, 32'h2);
      wr(pmr_pkg::IDX_IRQ_ENABLE_CLEAR, 32'h1);
      rd(pmr_pkg::IDX_IRQ_ENABLE_SET, 32'h2);
      // ready event with its enable off still sets the flag
      clock_ready_event <= 1'b1;
      @(posedge clk);
      clock_ready_event <= 1'b0;
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h1);
      check("irq", irq, 32'h0);
      wr(pmr_pkg::IDX_IRQ_FLAGS, 32'h1);
      // reserved bits dropped on write
      wr(pmr_pkg::IDX_MAIN_CONTROL, 32'hEF);
      rd(pmr_pkg::IDX_MAIN_CONTROL, 32'h04);
      wr(pmr_pkg::IDX_LOW_POWER_CONFIG, 32'hFF);
      rd(pmr_pkg::IDX_LOW_POWER_CONFIG, 32'h03);
      wr(pmr_pkg::IDX_RESET_PIN_CONTROL, 32'hFF);
      rd(pmr_pkg::IDX_RESET_PIN_CONTROL, 32'h01);
      check("pin_dis", rpd, 32'h1);
      check("fdet", fdon, 32'h1);
      clock_failure_event <= 1'b1;
      @(posedge clk);
      clock_failure_event <= 1'b0;
      repeat (2) @(posedge clk);
      check("backup", bsel, 32'h1);
      check("irq", irq, 32'h1);
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h2);
      wr(pmr_pkg::IDX_IRQ_FLAGS, 32'h2);
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h0);
      rd(pmr_pkg::IDX_MAIN_CONTROL, 32'h14);
      write_protect <= 1'b1;
      wr(pmr_pkg::IDX_MAIN_CONTROL, 32'h00);
      rd(pmr_pkg::IDX_MAIN_CONTROL, 32'h14);
      write_protect <= 1'b0;
      // narrow lanes: byte to a prescale select, byte 1 of a gate
      bus(1'b1, pmr_pkg::IDX_BUS_A_PRESCALE, 2'b00, pmr_pkg::HSIZE_BYTE, 32'hFF);
      bus(1'b0, pmr_pkg::IDX_BUS_A_PRESCALE, 2'b00, pmr_pkg::HSIZE_BYTE, 32'h07);
      bus(1'b1, pmr_pkg::IDX_BUS_C_GATE, 2'b01, pmr_pkg::HSIZE_BYTE, 32'h00000000);
      rd(pmr_pkg::IDX_BUS_C_GATE, 32'h000000FF);
      check("c_gate", g_c, 32'h000000FF);
      for (n = 0; n < 3; n++) begin
         r = $random(seed);
         wr(pmr_pkg::IDX_BUS_B_GATE, r);
         rd(pmr_pkg::IDX_BUS_B_GATE, r & pmr_pkg::BUS_B_GATE_MASK);
      end
      check("b_gate", g_b, r & pmr_pkg::BUS_B_GATE_MASK);
      check("bus_ticks", {t_b, t_c}, 32'h3);
      // divide by four: eight ticks in 32 cycles
      wr(pmr_pkg::IDX_CORE_PRESCALE, 32'h2);
      ticks = 0;
      repeat (32) @(negedge clk) ticks += int'(t_core === 1'b1);
      check("core_ticks", ticks, 32'd8);
      for (n = 0; n < 3; n++) begin
         wr(pmr_pkg::IDX_LOW_POWER_CONFIG, n);
         sleep_idle <= 1'b1;
         repeat (2) @(posedge clk);
         check("core_run", core_run, 32'h0);
         check("hs_run", hs_run, n == 0);
         check("pb_run", pb_run, n < 2);
         rd(pmr_pkg::IDX_LOW_POWER_CONFIG, n);
         if (n == 2) check("pb_ticks", {t_a, t_b, t_c}, 32'h0);
         sleep_idle <= 1'b0;
      end
      wr(pmr_pkg::IDX_MAIN_CONTROL, 32'h10);
      // failure with the detector off must not flag
      clock_failure_event <= 1'b1;
      @(posedge clk);
      clock_failure_event <= 1'b0;
      rd(pmr_pkg::IDX_IRQ_FLAGS, 32'h0);
      standby <= 1'b1;
      wr(pmr_pkg::IDX_MAIN_CONTROL, 32'h00);
      rd(pmr_pkg::IDX_MAIN_CONTROL, 32'h10);
      ondemand_req_pin <= 1'b1;
      async_irq_pin <= 1'b1;
      repeat (4) @(posedge clk);
      check("walk", walk_on, 32'h1);
      check("wake", wake, 32'h1);
      standby <= 1'b0;
      repeat (2) @(posedge clk);
      check("wake", wake, 32'h0);
      // second reset with a new cause, first request right after release
      nrst <= 1'b0;
      reset_cause <= 7'h2C;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("c_gate", g_c, pmr_pkg::BUS_C_GATE_RESET);
      check("backup", bsel, 32'h0);
      rd(pmr_pkg::IDX_LAST_RESET_SOURCE, {25'h0, 7'h2C & pmr_pkg::CAUSE_MASK});
      conclude();
   end
endmodule // tb
